// >>> common/zwc_pkg.sv
// zwc_pkg: constants and types for the zero-wait cache retry control
// Function
// - terminate every cacheable read but the reissued one from address valid alone, without waiting for tags
// - on a cacheable read miss assert bus fault and halt together before state 3
// - global match is the AND of the four tag slice match outputs
// - data RAM chip selects held active; reads gated only by output enable
// - data RAM outputs enabled by default, off only for writes or after a miss
// - cache reads end in two clocks, cacheable writes in three
// - no burst support; every read is a single longword cycle
// - never retry writes or noncacheable cycles; only cacheable read misses
// - on the reissued cycle suppress automatic termination; memory terminates it
// - hit needs all slices matching and the valid bit chosen by A3:A2
package zwc_pkg;

  // ==========================================================
  // geometry
  localparam int unsigned TAG_SLICES = 4;
  localparam int unsigned LW_SEL_W   = 2;

  // ==========================================================
  // cycle counts, in bus clocks from the cycle start
  localparam logic [1:0] READ_TERM_CLK  = 2'h1; // termination on second clock
  localparam logic [1:0] WRITE_TERM_CLK = 2'h2; // termination on third clock
  localparam logic [1:0] CNT_RESET      = 2'h0;

  // ==========================================================
  // controller states
  typedef enum logic [2:0] {
    ZWC_IDLE   = 3'b000,
    ZWC_READ   = 3'b001,
    ZWC_WRITE  = 3'b010,
    ZWC_RETRY  = 3'b011,
    ZWC_REISSUE= 3'b100,
    ZWC_DONE   = 3'b101
  } zwc_state_e;

endpackage

// >>> logic/zwc_hit_detect.sv
// zwc_hit_detect: combines tag slice matches and selected valid bit into hit
`timescale 1ns/10ps
module zwc_hit_detect (
  input  wire logic [zwc_pkg::TAG_SLICES-1:0] slice_match,
  input  wire logic [3:0]                     valid_bits,
  input  wire logic [zwc_pkg::LW_SEL_W-1:0]   lw_sel,
  output logic                                global_match,
  output logic                                hit
);
  import zwc_pkg::*;

  wire sel_valid;

  assign global_match = &slice_match;
  assign sel_valid    = valid_bits[lw_sel];
  assign hit          = global_match & sel_valid;
endmodule // zwc_hit_detect

// >>> logic/zwc_retry_ctrl.sv
// zwc_retry_ctrl: cycle termination, retry and data RAM enable control
`timescale 1ns/10ps
module zwc_retry_ctrl (
  input  wire logic                           ref_clk,
  input  wire logic                           rst_b,
  input  wire logic                           addr_strobe_n,
  input  wire logic                           read_not_write,
  input  wire logic                           cacheable,
  input  wire logic                           mem_term_n,
  input  wire logic [zwc_pkg::TAG_SLICES-1:0] slice_match,
  input  wire logic [3:0]                     valid_bits,
  input  wire logic [zwc_pkg::LW_SEL_W-1:0]   lw_sel,
  output logic                                sync_cycle_terminate_n,
  output logic                                bus_fault_n,
  output logic                                halt_n,
  output logic                                data_ram_cs_n,
  output logic                                data_ram_oe_n,
  output logic                                burst_ack_inhibit_n,
  output logic                                miss_seen
);
  import zwc_pkg::*;

  // ==========================================================
  // input synchronisers: all pins pass two flops before use
  logic [1:0] as_sync_r, rw_sync_r, ca_sync_r, mt_sync_r;
  logic [2*TAG_SLICES-1:0] sm_sync_r;
  logic [7:0] vb_sync_r;
  logic [3:0] ls_sync_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      as_sync_r <= 2'h3;
      rw_sync_r <= 2'h3;
      ca_sync_r <= 2'h0;
      mt_sync_r <= 2'h3;
      sm_sync_r <= '0;
      vb_sync_r <= 8'h00;
      ls_sync_r <= 4'h0;
    end else begin
      as_sync_r <= {as_sync_r[0], addr_strobe_n};
      rw_sync_r <= {rw_sync_r[0], read_not_write};
      ca_sync_r <= {ca_sync_r[0], cacheable};
      mt_sync_r <= {mt_sync_r[0], mem_term_n};
      sm_sync_r <= {sm_sync_r[TAG_SLICES-1:0], slice_match};
      vb_sync_r <= {vb_sync_r[3:0], valid_bits};
      ls_sync_r <= {ls_sync_r[1:0], lw_sel};
    end
  end

  wire as_n     = as_sync_r[1];
  wire rd       = rw_sync_r[1];
  wire cach     = ca_sync_r[1];
  wire mterm_n  = mt_sync_r[1];

  // ==========================================================
  // hit decode
  wire global_match;
  wire hit;

  zwc_hit_detect u_hit (
    .slice_match  (sm_sync_r[2*TAG_SLICES-1:TAG_SLICES]),
    .valid_bits   (vb_sync_r[7:4]),
    .lw_sel       (ls_sync_r[3:2]),
    .global_match (global_match),
    .hit          (hit)
  );

  // ==========================================================
  // state machine
  zwc_state_e state_r, state_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic       retry_pend_r, retry_pend_nxt;

  wire cyc_start  = !as_n;
  wire cache_rd   = cyc_start & cach & rd;
  wire cache_wr   = cyc_start & cach & !rd;
  // retry is only ever launched from a cacheable read
  wire read_miss  = (state_r == ZWC_READ) & !hit;

  // ==========================================================
  // write length decode, shared by the state machine and the termination decode
  // the counter holds the clock index since the strobe was seen; a cycle's first
  // state is entered on index READ_TERM_CLK, so a write ends one clock after a read
  // would have, and the two paths can never drift apart
  function automatic logic write_ends(input logic [1:0] clk_idx);
    return clk_idx == (WRITE_TERM_CLK - 2'h1);
  endfunction

  // reissue detection is positional: the first cacheable read after a retry is
  // taken to be the reissued cycle; a cacheable write in between does not clear it

  always_comb begin
    state_nxt      = state_r;
    cnt_nxt        = cnt_r;
    retry_pend_nxt = retry_pend_r;
    case (state_r)
      ZWC_IDLE: begin
        cnt_nxt = READ_TERM_CLK;
        if (cache_rd && retry_pend_r) begin
          state_nxt = ZWC_REISSUE;
        end else if (cache_rd) begin
          state_nxt = ZWC_READ;
        end else if (cache_wr) begin
          state_nxt = ZWC_WRITE;
        end
      end
      ZWC_READ: begin
        if (!hit) begin
          state_nxt      = ZWC_RETRY;
          retry_pend_nxt = 1'b1;
        end else begin
          state_nxt = ZWC_DONE;
        end
      end
      ZWC_WRITE: begin
        cnt_nxt = cnt_r + 2'h1;
        if (write_ends(cnt_r)) begin
          state_nxt = ZWC_DONE;
        end
      end
      // hold fault and halt until the strobe drops, i.e. processor sampled them
      ZWC_RETRY: begin
        if (as_n) begin
          state_nxt = ZWC_IDLE;
        end
      end
      ZWC_REISSUE: begin
        if (!mterm_n || as_n) begin
          retry_pend_nxt = 1'b0;
          state_nxt      = ZWC_DONE;
        end
      end
      ZWC_DONE: begin
        if (as_n) begin
          state_nxt = ZWC_IDLE;
        end
      end
      default: begin
        state_nxt = ZWC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r      <= ZWC_IDLE;
      cnt_r        <= CNT_RESET;
      retry_pend_r <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      retry_pend_r <= retry_pend_nxt;
    end
  end

  // ==========================================================
  // output decode; registered so every output comes from a flop
  // read termination comes from address valid alone so the hit path never gates it
  wire term_nxt    = (state_nxt == ZWC_READ)
                   | ((state_r == ZWC_WRITE) && write_ends(cnt_r));
  wire fault_nxt   = (state_nxt == ZWC_RETRY);
  // outputs stay on unless a write is in progress or a miss was found
  wire oe_off_nxt  = (state_nxt == ZWC_WRITE) | (state_nxt == ZWC_RETRY)
                   | (state_nxt == ZWC_REISSUE);

  logic term_r, fault_r, oe_off_r, miss_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      term_r   <= 1'b0;
      fault_r  <= 1'b0;
      oe_off_r <= 1'b0;
      miss_r   <= 1'b0;
    end else begin
      term_r   <= term_nxt;
      fault_r  <= fault_nxt;
      oe_off_r <= oe_off_nxt;
      miss_r   <= read_miss;
    end
  end

  assign sync_cycle_terminate_n = !term_r;
  assign bus_fault_n            = !fault_r;
  assign halt_n                 = !fault_r;
  assign data_ram_oe_n          = oe_off_r;
  assign miss_seen              = miss_r;

  // ==========================================================
  // constant outputs
  // chip selects tied active and burst never acknowledged, so the processor runs
  // single longword cycles; both still leave the block from flops
  logic cs_r, burst_inh_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_r        <= 1'b0;
      burst_inh_r <= 1'b1;
    end else begin
      cs_r        <= 1'b0;
      burst_inh_r <= 1'b1;
    end
  end
  assign data_ram_cs_n       = cs_r;
  assign burst_ack_inhibit_n = burst_inh_r;

endmodule // zwc_retry_ctrl

// >>> verification/tb_top.sv
// tb_top: self-checking bench for the retry controller
`timescale 1ns/10ps
module tb_top;
  logic ref_clk, rst_b, s_n, rnw, cach, mt_n, term_n, f_n, h_n, cs_n, oe_n, bi_n, miss;
  logic [3:0] slm, vb;
  logic [1:0] lw;
  int fail_count = 0, n_tests = 0, n_miss = 0;
  localparam int SYNC_LAT = 2; // two synchroniser flops ahead of every pin
  initial begin ref_clk = 0; forever #25 ref_clk = ~ref_clk; end
  always @(negedge ref_clk) if (miss === 1'b1) n_miss++;
  zwc_retry_ctrl u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .addr_strobe_n(s_n),
    .read_not_write(rnw), .cacheable(cach), .mem_term_n(mt_n), .slice_match(slm),
    .valid_bits(vb), .lw_sel(lw), .sync_cycle_terminate_n(term_n), .bus_fault_n(f_n),
    .halt_n(h_n), .data_ram_cs_n(cs_n), .data_ram_oe_n(oe_n), .burst_ack_inhibit_n(bi_n),
    .miss_seen(miss));
  zwc_cpu_model u_cpu (.ref_clk(ref_clk), .sync_cycle_terminate_n(term_n), .bus_fault_n(f_n),
    .halt_n(h_n), .data_ram_oe_n(oe_n), .addr_strobe_n(s_n), .read_not_write(rnw),
    .cacheable(cach), .mem_term_n(mt_n));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_hit();
    int m0;
    m0 = n_miss;
    for (int i = 0; i < 4; i++) begin
      slm = 4'hf; vb = 4'h1 << i; lw = i[1:0];
      u_cpu.run(1'b1, 1'b1);
      chk("hit end", u_cpu.cache_end, 1);
      chk("hit retry", u_cpu.retried, 0);
      chk("hit clk", u_cpu.n_clk, SYNC_LAT + zwc_pkg::READ_TERM_CLK);
      chk("hit oe", u_cpu.oe_off, 0);
    end
    chk("hit miss pulses", n_miss - m0, 0);
    $display("read hit done");
  endtask
  task automatic t_miss();
    int m0;
    for (int i = 0; i < 8; i++) begin
      lw = i[1:0];
      vb = (i < 4) ? ~(4'h1 << i) : 4'hf;
      slm = (i < 4) ? 4'hf : ~(4'h1 << (i - 4));
      m0 = n_miss;
      u_cpu.run(1'b1, 1'b1);
      chk("miss pulse", n_miss - m0, 1);
      chk("miss retry", u_cpu.retried, 1);
      chk("reissue end", u_cpu.cache_end, 0);
      chk("miss oe", u_cpu.oe_off, 1);
    end
    $display("read miss done");
  endtask
  task automatic t_other();
    slm = 4'h0; vb = 4'h0;
    u_cpu.run(1'b0, 1'b1);
    chk("wr retry", u_cpu.retried, 0);
    chk("wr end", u_cpu.cache_end, 1);
    chk("wr clk", u_cpu.n_clk, SYNC_LAT + zwc_pkg::WRITE_TERM_CLK);
    chk("wr oe", u_cpu.oe_off, 1);
    u_cpu.run(1'b1, 1'b0);
    chk("nc retry", u_cpu.retried, 0);
    chk("nc end", u_cpu.cache_end, 0);
    $display("write and noncacheable done");
  endtask
  task automatic t_reset();
    @(negedge ref_clk);
    rst_b = 1'b0;
    @(negedge ref_clk);
    chk("rst term", term_n, 1);
    chk("rst fault", f_n, 1);
    chk("rst halt", h_n, 1);
    chk("rst oe", oe_n, 0);
    chk("rst cs", cs_n, 0);
    chk("rst miss", miss, 0);
    rst_b = 1'b1;
    slm = 4'hf; vb = 4'hf; lw = 2'h0;
    u_cpu.run(1'b1, 1'b1);
    chk("rst hit end", u_cpu.cache_end, 1);
    chk("rst hit retry", u_cpu.retried, 0);
    $display("mid-run reset done");
  endtask
  initial begin
    rst_b = 0; slm = 4'hf; vb = 4'hf; lw = 2'h0;
    repeat (7) @(negedge ref_clk);
    rst_b = 1;
    repeat (3) @(negedge ref_clk);
    chk("cs", cs_n, 0);
    chk("burst", bi_n, 1);
    t_hit();
    t_miss();
    t_other();
    t_reset();
    end_of_test();
  end
  initial begin
    #(3000 * 50);
    fail_count++;
    end_of_test();
  end
endmodule // tb_top

// >>> verification/zwc_cpu_model.sv
// zwc_cpu_model: processor bus side with retry and memory termination
`timescale 1ns/10ps
module zwc_cpu_model (
  input  wire logic ref_clk,
  input  wire logic sync_cycle_terminate_n,
  input  wire logic bus_fault_n,
  input  wire logic halt_n,
  input  wire logic data_ram_oe_n,
  output logic      addr_strobe_n,
  output logic      read_not_write,
  output logic      cacheable,
  output logic      mem_term_n
);
  int unsigned n_clk;
  logic        retried, oe_off, cache_end;
  initial begin
    addr_strobe_n = 1'b1; read_not_write = 1'b1; cacheable = 1'b1; mem_term_n = 1'b1;
  end
  // slow memory ends whatever the cache leaves open
  task automatic phase();
    n_clk = 0; cache_end = 0;
    // design outputs are looked at on the falling edge, where they have settled
    repeat (12) begin
      @(negedge ref_clk);
      n_clk++;
      oe_off |= data_ram_oe_n;
      if (!sync_cycle_terminate_n) begin cache_end = 1; break; end
      if (!mem_term_n) break;
      mem_term_n = (n_clk != 8);
    end
    // fault and halt land one clock after the termination they cancel
    @(negedge ref_clk);
    oe_off |= data_ram_oe_n;
    retried |= !bus_fault_n && !halt_n;
    addr_strobe_n = 1'b1;
    mem_term_n = 1'b1;
  endtask
  task automatic run(input logic rd, input logic c);
    retried = 0; oe_off = 0;
    @(negedge ref_clk); read_not_write = rd; cacheable = c; addr_strobe_n = 1'b0;
    phase();
    if (retried) begin
      // idle until the fault clears, two more idle clocks, then the same cycle again
      repeat (6) if (!bus_fault_n) @(negedge ref_clk);
      repeat (2) @(negedge ref_clk);
      addr_strobe_n = 1'b0;
      phase();
    end
    repeat (4) @(negedge ref_clk);
  endtask
endmodule // zwc_cpu_model

// >>> verification/zwc_retry_sva.sv
// zwc_retry_sva: port-level assertions for the retry controller
`timescale 1ns/10ps
module zwc_retry_sva (
  input wire logic                           ref_clk,
  input wire logic                           rst_b,
  input wire logic                           addr_strobe_n,
  input wire logic                           read_not_write,
  input wire logic                           cacheable,
  input wire logic                           mem_term_n,
  input wire logic [zwc_pkg::TAG_SLICES-1:0] slice_match,
  input wire logic [3:0]                     valid_bits,
  input wire logic [zwc_pkg::LW_SEL_W-1:0]   lw_sel,
  input wire logic                           sync_cycle_terminate_n,
  input wire logic                           bus_fault_n,
  input wire logic                           halt_n,
  input wire logic                           data_ram_cs_n,
  input wire logic                           data_ram_oe_n,
  input wire logic                           burst_ack_inhibit_n,
  input wire logic                           miss_seen
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire hit_in = (&slice_match) && valid_bits[lw_sel];
  // ==========================================================
  // retry, termination and constant outputs
  a_cs_tied: assert property (!data_ram_cs_n) else $error("cs released");
  a_fault_halt_pair: assert property (bus_fault_n == halt_n) else $error("fault/halt split");
  a_no_burst: assert property (burst_ack_inhibit_n) else $error("burst acked");
  a_retry_scope: assert property (!bus_fault_n |-> read_not_write && cacheable)
    else $error("retry outside cacheable read");
  a_hit_no_fault: assert property (!sync_cycle_terminate_n && read_not_write && hit_in
    |=> bus_fault_n) else $error("retry on hit");
  a_miss_faults: assert property (!sync_cycle_terminate_n && read_not_write && !hit_in
    |=> !bus_fault_n && !halt_n) else $error("miss not retried");
  a_oe_off_fault: assert property (!bus_fault_n |-> data_ram_oe_n) else $error("oe on miss");
  a_term_pulse: assert property (!sync_cycle_terminate_n |=> sync_cycle_terminate_n)
    else $error("term too long");
  a_term_cause: assert property (!sync_cycle_terminate_n |-> cacheable && !$past(addr_strobe_n, 2))
    else $error("term without cycle");
  a_fault_release: assert property ($rose(addr_strobe_n) && !bus_fault_n |-> ##[1:4] bus_fault_n)
    else $error("fault held");
endmodule // zwc_retry_sva
bind zwc_retry_ctrl zwc_retry_sva u_sva (
  .ref_clk                (ref_clk),
  .rst_b                  (rst_b),
  .addr_strobe_n          (addr_strobe_n),
  .read_not_write         (read_not_write),
  .cacheable              (cacheable),
  .mem_term_n             (mem_term_n),
  .slice_match            (slice_match),
  .valid_bits             (valid_bits),
  .lw_sel                 (lw_sel),
  .sync_cycle_terminate_n (sync_cycle_terminate_n),
  .bus_fault_n            (bus_fault_n),
  .halt_n                 (halt_n),
  .data_ram_cs_n          (data_ram_cs_n),
  .data_ram_oe_n          (data_ram_oe_n),
  .burst_ack_inhibit_n    (burst_ack_inhibit_n),
  .miss_seen              (miss_seen)
);
